// ### hw/rftc_timer.sv
// Second event timer: configuration registers, event selection and down counter
`timescale 1ns/1ps

// Contract
// - Halt after receive begins and four bits arrive
// - Halt when transmission begins
// - Halt when external field appears
// - Halt when external field vanishes
// - Halt when internal field turns on
// - Halt when internal field turns off
// - Run when first received bit arrives
// - Run when reception ends
// - Run when transmission begins
// - Run when transmission ends
// - Run when external field appears
// - Run when external field vanishes
// - Run when internal field turns on
// - Run when internal field turns off
// - Run immediately without any event
// - Rate code picks 6.78 MHz to 53 kHz
// - Prescaler use picks frontend clock or rate
// - Without reload, stop at zero on expiry
// - With reload, reload preset and continue
// - Operate only while enabled; config resets zero
module rftc_timer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire rftc_pkg::rftc_xcvr_t xcvr_events,
    input wire logic external_field_pin,
    input wire logic internal_field_on,
    output logic timer_expired,
    output logic timer_running,
    output logic [15:0] timer_count
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus

    logic [rftc_pkg::CFG_W-1:0] cfg_reg;
    logic [rftc_pkg::COUNT_W-1:0] preset_reg;
    logic [rftc_pkg::COUNT_W-1:0] count_reg;
    logic [rftc_pkg::COUNT_W-1:0] count_next;
    rftc_pkg::rftc_state_t state_reg;
    rftc_pkg::rftc_state_t state_next;
    logic ack_reg;
    logic [31:0] readdata_reg;
    logic [31:0] read_word;
    logic [31:0] cfg_word;
    logic [31:0] preset_word;
    logic [31:0] wr_merge_cfg;
    logic [31:0] wr_merge_preset;
    logic bus_req;
    logic wr_take;

    assign bus_req = avs_read | avs_write;
    // One wait cycle keeps read data registered
    assign avs_waitrequest = bus_req & ~ack_reg;
    assign wr_take = avs_write & ack_reg & clk_en;
    assign avs_readdata = readdata_reg;
    assign cfg_word = {{(32-rftc_pkg::CFG_W){1'b0}}, cfg_reg};
    assign preset_word = {{(32-rftc_pkg::COUNT_W){1'b0}}, preset_reg};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
        end else if (clk_en) begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    always_comb begin
        unique case (avs_address)
            rftc_pkg::CFG_OFFSET: read_word = cfg_word;
            rftc_pkg::PRESET_OFFSET: read_word = preset_word;
            rftc_pkg::STATUS_OFFSET: read_word = {14'h0000, state_reg, count_reg};
            default: read_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readdata_reg <= 32'h00000000;
        end else if (clk_en && avs_read && !ack_reg) begin
            readdata_reg <= read_word;
        end
    end

    // Byte lanes merge into the stored words
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign wr_merge_cfg[lane*8 +: 8] = avs_byteenable[lane] ?
                avs_writedata[lane*8 +: 8] : cfg_word[lane*8 +: 8];
            assign wr_merge_preset[lane*8 +: 8] = avs_byteenable[lane] ?
                avs_writedata[lane*8 +: 8] : preset_word[lane*8 +: 8];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_reg <= rftc_pkg::CFG_RESET;
        end else if (wr_take && avs_address == rftc_pkg::CFG_OFFSET) begin
            cfg_reg <= wr_merge_cfg[rftc_pkg::CFG_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            preset_reg <= rftc_pkg::PRESET_RESET;
        end else if (wr_take && avs_address == rftc_pkg::PRESET_OFFSET) begin
            preset_reg <= wr_merge_preset[rftc_pkg::COUNT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Field inputs and edges

    logic [2:0] ext_sync_reg;
    logic ext_level_reg;
    logic int_level_reg;
    logic ext_rise;
    logic ext_fall;
    logic int_rise;
    logic int_fall;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_sync_reg <= 3'h0;
        end else if (clk_en) begin
            ext_sync_reg <= {ext_sync_reg[1:0], external_field_pin};
        end
    end

    // Level changes only once stages two and three agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_level_reg <= 1'b0;
        end else if (clk_en && ext_sync_reg[1] == ext_sync_reg[2]) begin
            ext_level_reg <= ext_sync_reg[2];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_level_reg <= 1'b0;
        end else if (clk_en) begin
            int_level_reg <= internal_field_on;
        end
    end

    // Field seen present at reset release counts as a rising edge
    assign ext_rise = ext_sync_reg[1] & ext_sync_reg[2] & ~ext_level_reg;
    assign ext_fall = ~ext_sync_reg[1] & ~ext_sync_reg[2] & ext_level_reg;
    assign int_rise = internal_field_on & ~int_level_reg;
    assign int_fall = ~internal_field_on & int_level_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Event selection

    logic halt_hit;
    logic run_hit;
    logic [5:0] halt_terms;
    logic [8:0] run_terms;

    assign halt_terms[0] = cfg_reg[rftc_pkg::HALT_RX_BEGIN_BIT] & xcvr_events.rx_nibble;
    assign halt_terms[1] = cfg_reg[rftc_pkg::HALT_TX_BEGIN_BIT] & xcvr_events.tx_begin;
    assign halt_terms[2] = cfg_reg[rftc_pkg::HALT_EXT_ON_BIT] & ext_rise;
    assign halt_terms[3] = cfg_reg[rftc_pkg::HALT_EXT_OFF_BIT] & ext_fall;
    assign halt_terms[4] = cfg_reg[rftc_pkg::HALT_INT_ON_BIT] & int_rise;
    assign halt_terms[5] = cfg_reg[rftc_pkg::HALT_INT_OFF_BIT] & int_fall;

    assign run_terms[0] = cfg_reg[rftc_pkg::RUN_RX_BEGIN_BIT] & xcvr_events.rx_begin;
    assign run_terms[1] = cfg_reg[rftc_pkg::RUN_RX_END_BIT] & xcvr_events.rx_end;
    assign run_terms[2] = cfg_reg[rftc_pkg::RUN_TX_BEGIN_BIT] & xcvr_events.tx_begin;
    assign run_terms[3] = cfg_reg[rftc_pkg::RUN_TX_END_BIT] & xcvr_events.tx_end;
    assign run_terms[4] = cfg_reg[rftc_pkg::RUN_EXT_ON_BIT] & ext_rise;
    assign run_terms[5] = cfg_reg[rftc_pkg::RUN_EXT_OFF_BIT] & ext_fall;
    assign run_terms[6] = cfg_reg[rftc_pkg::RUN_INT_ON_BIT] & int_rise;
    assign run_terms[7] = cfg_reg[rftc_pkg::RUN_INT_OFF_BIT] & int_fall;
    // Acts from ARMED only: run-now cannot restart an expired timer, other run events can
    assign run_terms[8] = cfg_reg[rftc_pkg::RUN_NOW_BIT] &
                          (state_reg == rftc_pkg::RFTC_ARMED);

    assign halt_hit = |halt_terms;
    assign run_hit = |run_terms;

    ////////////////////////////////////////////////////////////////////////////////
    // Tick generation

    logic [rftc_pkg::PHASE_W:0] phase_sum;
    logic [rftc_pkg::PHASE_W-1:0] phase_reg;
    logic fe_tick;
    logic [rftc_pkg::DIV_W-1:0] div_reg;
    logic [rftc_pkg::DIV_W-1:0] div_mask;
    logic pre_tick;
    logic tick;
    logic [rftc_pkg::RATE_W-1:0] rate_sel;

    // Frontend clock made by phase accumulation; jitter is one system cycle
    assign phase_sum = {1'b0, phase_reg} + {1'b0, rftc_pkg::PHASE_INC};
    assign fe_tick = phase_sum[rftc_pkg::PHASE_W];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_reg <= '0;
        end else if (clk_en) begin
            phase_reg <= phase_sum[rftc_pkg::PHASE_W-1:0];
        end
    end

    // Divider runs only while counting so the first tick is a full period
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_reg <= '0;
        end else if (clk_en) begin
            if (state_reg != rftc_pkg::RFTC_RUN) begin
                div_reg <= '0;
            end else if (fe_tick) begin
                div_reg <= div_reg + 1'b1;
            end
        end
    end

    // Code n divides the frontend clock by two to the n plus one
    assign rate_sel = cfg_reg[rftc_pkg::RATE_LSB +: rftc_pkg::RATE_W];
    assign div_mask = rftc_pkg::DIV_W'((9'h002 << rate_sel) - 9'h001);
    assign pre_tick = fe_tick & ((div_reg & div_mask) == div_mask);
    assign tick = cfg_reg[rftc_pkg::PRESCALER_USE_BIT] ? pre_tick : fe_tick;

    ////////////////////////////////////////////////////////////////////////////////
    // Counter state machine

    logic enabled;
    logic expire_hit;
    logic expired_reg;

    assign enabled = cfg_reg[rftc_pkg::TIMER_ON_BIT];
    assign expire_hit = (state_reg == rftc_pkg::RFTC_RUN) && tick && !halt_hit &&
                        (count_reg <= 16'h0001);

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        if (!enabled) begin
            state_next = rftc_pkg::RFTC_IDLE;
        end else begin
            unique case (state_reg)
                rftc_pkg::RFTC_IDLE: begin
                    state_next = rftc_pkg::RFTC_ARMED;
                end
                rftc_pkg::RFTC_ARMED, rftc_pkg::RFTC_HALTED: begin
                    if (run_hit) begin
                        state_next = rftc_pkg::RFTC_RUN;
                        count_next = preset_reg;
                    end
                end
                rftc_pkg::RFTC_RUN: begin
                    if (halt_hit) begin
                        // Stop beats a same-cycle tick: count is frozen
                        state_next = rftc_pkg::RFTC_HALTED;
                    end else if (expire_hit) begin
                        if (cfg_reg[rftc_pkg::AUTO_RELOAD_BIT]) begin
                            count_next = preset_reg;
                        end else begin
                            count_next = 16'h0000;
                            // Parked, so run-now cannot restart it
                            state_next = rftc_pkg::RFTC_HALTED;
                        end
                    end else if (tick) begin
                        count_next = count_reg - 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= rftc_pkg::RFTC_IDLE;
            count_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            expired_reg <= 1'b0;
        end else if (clk_en) begin
            expired_reg <= expire_hit & enabled;
        end
    end

    assign timer_expired = expired_reg;
    assign timer_running = state_reg == rftc_pkg::RFTC_RUN;
    assign timer_count = count_reg;

endmodule

// ### hw/rftc_pkg.sv
// Constants and types shared by the second event timer control block
package rftc_pkg;

    // Register byte addresses
    localparam logic [7:0] CFG_OFFSET = 8'h10;
    localparam logic [7:0] PRESET_OFFSET = 8'h14;
    localparam logic [7:0] STATUS_OFFSET = 8'h18;

    // Configuration field positions
    localparam int HALT_RX_BEGIN_BIT = 20;
    localparam int HALT_TX_BEGIN_BIT = 19;
    localparam int HALT_EXT_ON_BIT = 18;
    localparam int HALT_EXT_OFF_BIT = 17;
    localparam int HALT_INT_ON_BIT = 16;
    localparam int HALT_INT_OFF_BIT = 15;
    localparam int RUN_RX_BEGIN_BIT = 14;
    localparam int RUN_RX_END_BIT = 13;
    localparam int RUN_TX_BEGIN_BIT = 12;
    localparam int RUN_TX_END_BIT = 11;
    localparam int RUN_EXT_ON_BIT = 10;
    localparam int RUN_EXT_OFF_BIT = 9;
    localparam int RUN_INT_ON_BIT = 8;
    localparam int RUN_INT_OFF_BIT = 7;
    localparam int RUN_NOW_BIT = 6;
    localparam int RATE_LSB = 3;
    localparam int RATE_W = 3;
    localparam int PRESCALER_USE_BIT = 2;
    localparam int AUTO_RELOAD_BIT = 1;
    localparam int TIMER_ON_BIT = 0;
    localparam int CFG_W = 21;
    localparam int COUNT_W = 16;
    localparam int STATE_LSB = 16;

    // Reset values
    localparam logic [CFG_W-1:0] CFG_RESET = 21'h000000;
    localparam logic [COUNT_W-1:0] PRESET_RESET = 16'h0000;

    // Frontend clock rate synthesised from the system clock
    localparam longint SYS_CLK_HZ = 125000000;
    localparam longint FRONTEND_CLK_HZ = 13560000;
    localparam int PHASE_W = 24;
    localparam logic [PHASE_W-1:0] PHASE_INC =
        PHASE_W'((FRONTEND_CLK_HZ * (64'd1 << PHASE_W)) / SYS_CLK_HZ);
    localparam int DIV_W = 8;

    typedef enum logic [1:0] {
        RFTC_IDLE = 2'b00,
        RFTC_ARMED = 2'b01,
        RFTC_RUN = 2'b11,
        RFTC_HALTED = 2'b10
    } rftc_state_t;

    // Transceiver events, one-cycle pulses on clk
    typedef struct packed {
        logic rx_begin;
        logic rx_nibble;
        logic rx_end;
        logic tx_begin;
        logic tx_end;
    } rftc_xcvr_t;

endpackage

// ### tb/rftc_timer_props.sv
// Assertion checker for the second event timer
`timescale 1ns/1ps
module rftc_timer_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire rftc_pkg::rftc_xcvr_t xcvr_events,
    input wire logic external_field_pin,
    input wire logic internal_field_on,
    input wire logic timer_expired,
    input wire logic timer_running,
    input wire logic [15:0] timer_count
);
    // Shadow copies; full-word writes only, the bench never sends partial ones
    logic [20:0] cfg_reg;
    logic [15:0] pre_reg;
    logic take;
    assign take = clk_en && avs_write && !avs_waitrequest && avs_byteenable == 4'hf;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_reg <= '0;
            pre_reg <= '0;
        end else if (take && avs_address == rftc_pkg::CFG_OFFSET) begin
            cfg_reg <= avs_writedata[20:0];
        end else if (take && avs_address == rftc_pkg::PRESET_OFFSET) begin
            pre_reg <= avs_writedata[15:0];
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_one_wait;
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus wait not one cycle");
    property p_rd_cfg;
        avs_read && !avs_waitrequest && avs_address == rftc_pkg::CFG_OFFSET
            |-> avs_readdata == {11'h0, cfg_reg};
    endproperty
    a_rd_cfg: assert property (p_rd_cfg) else $error("config readback wrong");
    property p_disabled;
        clk_en && !cfg_reg[0] |=> !timer_running;
    endproperty
    a_disabled: assert property (p_disabled) else $error("runs while disabled");
    property p_halt_tx;
        timer_running && clk_en && cfg_reg[19] && xcvr_events.tx_begin |=> !timer_running;
    endproperty
    a_halt_tx: assert property (p_halt_tx) else $error("no halt on transmit");
    property p_halt_rx;
        timer_running && clk_en && cfg_reg[20] && xcvr_events.rx_nibble |=> !timer_running;
    endproperty
    a_halt_rx: assert property (p_halt_rx) else $error("no halt on receive");
    property p_freeze;
        !timer_running && clk_en |=> timer_running || $stable(timer_count);
    endproperty
    a_freeze: assert property (p_freeze) else $error("count moved while stopped");
    property p_step;
        timer_running && clk_en && timer_count > 16'h1
            |=> timer_count == $past(timer_count) || timer_count == $past(timer_count) - 16'h1;
    endproperty
    a_step: assert property (p_step) else $error("count step not one");
    property p_no_reload;
        timer_expired && !cfg_reg[1] |-> timer_count == 16'h0 || $past(timer_count) == 16'h0;
    endproperty
    a_no_reload: assert property (p_no_reload) else $error("expiry not at zero");
    property p_reload;
        timer_expired && cfg_reg[1] |-> timer_count == pre_reg || $past(timer_count) == pre_reg;
    endproperty
    a_reload: assert property (p_reload) else $error("reload value wrong");
    property p_pulse;
        timer_expired && clk_en |=> !timer_expired;
    endproperty
    a_pulse: assert property (p_pulse) else $error("expiry pulse too long");
    c_reload: cover property (timer_expired && cfg_reg[1]);
    c_halted: cover property ($fell(timer_running) && cfg_reg[0]);
    c_rx_halt: cover property (timer_running && cfg_reg[20] && xcvr_events.rx_nibble);
endmodule
bind rftc_timer rftc_timer_props i_rftc_timer_props (.clk, .sys_rst, .clk_en, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .xcvr_events, .external_field_pin, .internal_field_on, .timer_expired, .timer_running,
    .timer_count);

// ### tb/rftc_timer_test.sv
// Self-checking bench for the second event timer
`timescale 1ns/1ps
module rftc_timer_test;
    logic clk, sys_rst, clk_en, avs_read, avs_write, external_field_pin, internal_field_on;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, v;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest, timer_expired, timer_running;
    logic [15:0] timer_count, c;
    rftc_pkg::rftc_xcvr_t xcvr_events;
    int num_errors, checked, cyc, n;
    int xb[9] = '{4, 2, 1, 0, 3, 0, 0, 0, 0};
    int runb[9] = '{14, 13, 12, 11, 0, 10, 9, 8, 7};
    int haltb[9] = '{0, 0, 19, 0, 20, 18, 17, 16, 15};
    rftc_timer i_rftc_timer (.clk, .sys_rst, .clk_en, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .xcvr_events,
        .external_field_pin, .internal_field_on, .timer_expired, .timer_running, .timer_count);
    ////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // Field levels set opposite to the coming edge, then settle past the synchroniser
    task automatic prep(input int ev);
        external_field_pin <= (ev == 6);
        internal_field_on <= (ev == 8);
        repeat (6) @(posedge clk);
    endtask
    task automatic fire(input int ev);
        if (ev < 5) xcvr_events <= rftc_pkg::rftc_xcvr_t'(5'h1 << xb[ev]);
        else if (ev < 7) external_field_pin <= (ev == 5);
        else internal_field_on <= (ev == 7);
        @(posedge clk);
        xcvr_events <= '0;
    endtask
    task automatic wait_run(input logic w);
        for (n = 0; n < 12 && timer_running !== w; n++) @(posedge clk);
    endtask
    function automatic real tick_cycles(input int m);
        return 125.0 / 13.56 * (m < 8 ? 2.0 ** (m + 1) : 1.0);
    endfunction
    ////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {avs_read, avs_write, external_field_pin, internal_field_on} = 4'h0;
        {avs_address, avs_writedata, xcvr_events} = '0;
        avs_byteenable = 4'hf;
        clk_en = 1'b1;
        sys_rst = 1'b1;
        void'($urandom(16));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rdc("cfg reset", rftc_pkg::CFG_OFFSET, 32'h0);
        rdc("unmapped", 8'h04, 32'h0);
        bus(1'b1, rftc_pkg::CFG_OFFSET, 32'hffff_ffff);
        rdc("cfg width", rftc_pkg::CFG_OFFSET, 32'h001f_ffff);
        bus(1'b1, rftc_pkg::CFG_OFFSET, 32'h0);
        $display("register test done");
        bus(1'b1, rftc_pkg::PRESET_OFFSET, 32'h0000_ffff);
        rdc("preset", rftc_pkg::PRESET_OFFSET, 32'h0000_ffff);
        for (int m = 0; m < 9; m++) begin
            bus(1'b1, rftc_pkg::CFG_OFFSET, 32'h41 | (m < 8 ? 32'h4 | (m << 3) : 32'h0));
            wait_run(1'b1);
            chk("run now", 32'h1, 32'(timer_running));
            c = timer_count;
            for (n = 0; n < 3000 && timer_count === c; n++) @(posedge clk);
            c = timer_count;
            for (n = 0; n < 6000 && timer_count > c - 16'h2; n++) @(posedge clk);
            chk("tick period", 32'h1,
                32'(n > 2.0 * tick_cycles(m) * 0.97 - 2 && n < 2.0 * tick_cycles(m) * 1.03 + 2));
            bus(1'b1, rftc_pkg::CFG_OFFSET, 32'h0);
        end
        $display("rate test done");
        bus(1'b1, rftc_pkg::PRESET_OFFSET, 32'h3);
        for (int r = 0; r < 2; r++) begin
            bus(1'b1, rftc_pkg::CFG_OFFSET, r ? 32'h43 : 32'h41);
            if (!r) bus(1'b1, rftc_pkg::CFG_OFFSET, 32'h1);
            for (n = 0; n < 200 && timer_expired !== 1'b1; n++) @(posedge clk);
            chk("expiry seen", 32'h1, 32'(timer_expired));
            repeat (3) @(posedge clk);
            chk("after expiry", r ? 32'h1 : 32'h0, 32'(timer_running));
            chk("count after expiry", r ? 32'h3 : 32'h0, 32'(timer_count));
            if (!r) rdc("status halted", rftc_pkg::STATUS_OFFSET,
                32'(rftc_pkg::RFTC_HALTED) << rftc_pkg::STATE_LSB);
            bus(1'b1, rftc_pkg::CFG_OFFSET, 32'h0);
        end
        $display("expiry test done");
        bus(1'b1, rftc_pkg::PRESET_OFFSET, 32'h0100 | 32'($urandom_range(0, 16'hfeff)));
        for (int ev = 0; ev < 9; ev++) begin
            prep(ev);
            if (runb[ev] != 0) begin
                bus(1'b1, rftc_pkg::CFG_OFFSET, 32'h1 | (32'h1 << runb[ev]));
                repeat (4) @(posedge clk);
                chk("armed idle", 32'h0, 32'(timer_running));
                fire(ev);
                wait_run(1'b1);
                chk("run event", 32'h1, 32'(timer_running));
                // Disarm, then set field levels again for the halt case
                bus(1'b1, rftc_pkg::CFG_OFFSET, 32'h0);
                prep(ev);
            end
            if (haltb[ev] != 0) begin
                bus(1'b1, rftc_pkg::CFG_OFFSET, 32'h801 | (32'h1 << haltb[ev]));
                fire(3);
                repeat (20) @(posedge clk);
                fire(ev);
                wait_run(1'b0);
                chk("halt event", 32'h0, 32'(timer_running));
                // Count must hold while halted
                c = timer_count;
                repeat (30) @(posedge clk);
                chk("frozen", 32'(c), 32'(timer_count));
                bus(1'b1, rftc_pkg::CFG_OFFSET, 32'h0);
            end
            $display("event %0d test done", ev);
        end
        for (int r = 0; r < 4; r++) begin
            bus(1'b1, rftc_pkg::PRESET_OFFSET, 32'($urandom_range(0, 40)));
            v = (32'($urandom) & 32'h001f_ffff) | 32'h1;
            bus(1'b1, rftc_pkg::CFG_OFFSET, v);
            repeat (300) begin
                xcvr_events <= ($urandom_range(0, 7) == 0) ? 5'h1 << $urandom_range(0, 4) : 5'h0;
                if ($urandom_range(0, 30) == 0) external_field_pin <= !external_field_pin;
                if ($urandom_range(0, 30) == 0) internal_field_on <= !internal_field_on;
                clk_en <= ($urandom_range(0, 9) != 0);
                @(posedge clk);
            end
            xcvr_events <= '0;
            clk_en <= 1'b1;
            @(posedge clk);
            rdc("cfg kept", rftc_pkg::CFG_OFFSET, v);
            $display("random round %0d done", r);
        end
        print_verdict();
    end
endmodule
